// ==== include/gsp_map.svh ====
// Command codes, opcodes, bit positions, offsets and counts
`ifndef GSP_MAP_SVH
`define GSP_MAP_SVH
// Bus commands sent with attention
`define GSP_UNL 8'h3F
`define GSP_UNT 8'h5F
`define GSP_LAG 8'h20
`define GSP_TAG 8'h40
`define GSP_TAG_HI 3'h2
`define GSP_SPE 8'h18
`define GSP_SPD 8'h19
`define GSP_PPC 8'h05
`define GSP_PPU 8'h15
`define GSP_PPE 4'h6
`define GSP_PPD 8'h70
// Program message opcodes sent as data
`define GSP_OP_CHGEN 8'h01
`define GSP_OP_SRE 8'h02
`define GSP_OP_PRE 8'h03
`define GSP_OP_CLS 8'h04
`define GSP_OP_HDR 8'h05
`define GSP_OP_QSTB 8'h06
`define GSP_OP_QCHG 8'h07
`define GSP_OP_QIST 8'h08
// Status byte bit positions
`define GSP_STB_SUM 0
`define GSP_STB_MAV 4
`define GSP_STB_RQS 6
// Reset values
`define GSP_HDR_RST 1'b1
`define GSP_ADDR_RST 5'h04
// Controller register byte offsets and fields
`define GSP_A_TX 4'h0
`define GSP_A_RX 4'h4
`define GSP_A_PP 4'h8
`define GSP_A_ST 4'hC
`define GSP_TX_ATN 8
// Cycles the controller waits for a talker byte
`define GSP_RD_TMO 4'hF
`endif

// ==== include/gsp_pkg.sv ====
// Types shared by both ends of the status poll link
package gsp_pkg;
    typedef enum logic {GSP_PS_OP, GSP_PS_VAL} gsp_parse_e;
    typedef enum logic [1:0] {
        GSP_C_IDLE, GSP_C_RD, GSP_C_PP1, GSP_C_PP2
    } gsp_cst_e;
    typedef struct packed {
        logic lsn;
        logic tlk;
        logic spm;
        logic ppc_pend;
        logic pp_en;
        logic pp_sense;
        logic [2:0] pp_line;
        logic [7:0] chg_en;
        logic [7:0] sre;
        logic [7:0] pre;
        logic hdr;
        logic [7:0] icr;
        logic sum_bit;
        logic [7:0] sum_prev;
        logic rqs;
        logic [7:0] op;
        gsp_parse_e pst;
        logic [15:0] resp;
        logic [1:0] rcnt;
        logic [7:0] dio;
        logic [7:0] oe;
        logic ack;
        logic srq;
        logic [7:0] stb;
        logic ist;
    } gsp_dev_s;
    typedef struct packed {
        logic wreq;
        logic [31:0] rdata;
        logic [7:0] dio;
        logic dio_oe;
        logic atn;
        logic dav;
        logic rd;
        logic idy;
        gsp_cst_e st;
        logic [3:0] tmo;
        logic [7:0] rx;
        logic rx_v;
        logic rx_err;
        logic [7:0] ppr;
    } gsp_ctl_s;
endpackage : gsp_pkg

// ==== include/gsp_if.sv ====
// Link between bus controller and status poll responder
`timescale 1ns/1ps
interface gsp_if;
    logic [7:0] ctl_dio;
    logic ctl_dio_oe;
    logic atn;
    logic dav;
    logic rd;
    logic idy;
    logic [7:0] dev_dio;
    logic [7:0] dev_dio_oe;
    logic ack;
    logic srq;
    logic [7:0] dio_bus;
    // Wired-OR data lines from all enabled drivers
    assign dio_bus = (ctl_dio & {8{ctl_dio_oe}}) | (dev_dio & dev_dio_oe);
    modport dev (
        input dio_bus, atn, dav, rd, idy,
        output dev_dio, dev_dio_oe, ack, srq
    );
    modport ctl (
        input dio_bus, ack, srq,
        output ctl_dio, ctl_dio_oe, atn, dav, rd, idy
    );
endinterface : gsp_if

// ==== design/gsp_device.sv ====
// Status summary, service request and poll responder
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "gsp_map.svh"
module gsp_device import gsp_pkg::*; #(
    parameter logic [4:0] PRI_ADDR = `GSP_ADDR_RST
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    gsp_if.dev bus,
    input wire logic [7:0] event_i,
    output logic [7:0] status_byte_o,
    output logic ist_o
);
    // Own listen and talk address bytes
    localparam logic [7:0] MY_LAG = `GSP_LAG + {3'h0, PRI_ADDR};
    localparam logic [7:0] MY_TAG = `GSP_TAG + {3'h0, PRI_ADDR};

    // Addresses above 30 cannot be listened to
    if (PRI_ADDR > 5'h1E) begin : g_bad_addr
        $error("primary address must be 0 to 30");
    end

    gsp_dev_s s;
    gsp_dev_s n;
    logic [7:0] b;
    logic [7:0] stb;
    logic [7:0] sum;
    logic ist;

    // Response bytes with or without the opcode as header
    function automatic logic [17:0] rsp_load(
        input logic hdr,
        input logic [7:0] op,
        input logic [7:0] val
    );
        // Count 2 sends opcode then value, count 1 the value only
        rsp_load = hdr ? {op, val, 2'd2} : {8'h00, val, 2'd1};
    endfunction : rsp_load

    // Status byte assembled from its sources
    always_comb begin
        stb = 8'h00;
        stb[`GSP_STB_SUM] = s.sum_bit;
        stb[`GSP_STB_MAV] = s.rcnt != 2'd0;
        stb[`GSP_STB_RQS] = s.rqs;
    end

    // Summary terms and individual status
    assign b = bus.dio_bus;
    // Request bit itself never feeds the request edge
    assign sum = stb & s.sre & ~(8'h01 << `GSP_STB_RQS);
    assign ist = |(stb & s.pre);

    // Next state
    always_comb begin
        logic c_icr;
        logic c_inb;
        logic c_rqs;
        c_icr = 1'b0;
        c_inb = 1'b0;
        c_rqs = 1'b0;
        n = s;
        n.ack = 1'b0;
        n.oe = 8'h00;
        n.dio = 8'h00;
        // Bus commands under attention
        // Other devices' talk addresses clear talk; their listen addresses fall through and change nothing
        if (bus.dav && bus.atn) begin
            if (b == `GSP_UNL) begin
                n.lsn = 1'b0;
                n.ppc_pend = 1'b0;
            end else if (b == `GSP_UNT) begin
                n.tlk = 1'b0;
            end else if (b == MY_LAG) begin
                n.lsn = 1'b1;
            end else if (b == MY_TAG) begin
                n.tlk = 1'b1;
            end else if (b[7:5] == `GSP_TAG_HI) begin
                n.tlk = 1'b0;
            end else if (b == `GSP_SPE) begin
                n.spm = 1'b1;
            end else if (b == `GSP_SPD) begin
                n.spm = 1'b0;
            end else if (b == `GSP_PPC) begin
                n.ppc_pend = s.lsn;
            end else if (b == `GSP_PPU) begin
                n.pp_en = 1'b0;
                n.ppc_pend = 1'b0;
            end else if (s.ppc_pend && b[7:4] == `GSP_PPE) begin
                n.pp_en = 1'b1;
                n.pp_sense = b[3];
                n.pp_line = b[2:0];
                n.ppc_pend = 1'b0;
            end else if (s.ppc_pend && b == `GSP_PPD) begin
                n.pp_en = 1'b0;
                n.ppc_pend = 1'b0;
            end
        end else if (bus.dav && s.lsn) begin
            // Program messages while listening
            if (s.pst == GSP_PS_VAL) begin
                n.pst = GSP_PS_OP;
                case (s.op)
                    `GSP_OP_CHGEN: n.chg_en = b;
                    `GSP_OP_SRE: n.sre = b;
                    `GSP_OP_PRE: n.pre = b;
                    `GSP_OP_HDR: n.hdr = b[0];
                    default: ;
                endcase
            end else begin
                n.op = b;
                case (b)
                    `GSP_OP_CHGEN, `GSP_OP_SRE, `GSP_OP_PRE,
                    `GSP_OP_HDR: begin
                        n.pst = GSP_PS_VAL;
                    end
                    `GSP_OP_CLS: begin
                        c_icr = 1'b1;
                        c_inb = 1'b1;
                        c_rqs = 1'b1;
                        n.rcnt = 2'd0;
                    end
                    `GSP_OP_QSTB: begin
                        {n.resp, n.rcnt} = rsp_load(s.hdr, b, stb);
                        c_inb = 1'b1;
                    end
                    `GSP_OP_QCHG: begin
                        {n.resp, n.rcnt} = rsp_load(s.hdr, b, s.icr);
                        c_icr = 1'b1;
                    end
                    `GSP_OP_QIST: begin
                        {n.resp, n.rcnt} = rsp_load(s.hdr, b,
                            {7'h00, ist});
                    end
                    default: ;
                endcase
            end
        end
        // Talker byte: status byte in serial poll, else response
        if (bus.rd && s.tlk) begin
            n.ack = 1'b1;
            n.oe = 8'hFF;
            if (s.spm) begin
                n.dio = stb;
                c_rqs = 1'b1;
            end else if (s.rcnt != 2'd0) begin
                n.dio = (s.rcnt == 2'd2) ? s.resp[15:8] : s.resp[7:0];
                n.rcnt = s.rcnt - 2'd1;
            end
        end
        // Parallel poll answer on the assigned line only
        // Sense bit picks whether a set or a clear status answers
        if (bus.idy && s.pp_en && (ist == s.pp_sense)) begin
            n.oe[s.pp_line] = 1'b1;
            n.dio[s.pp_line] = 1'b1;
        end
        // Sticky bits, a set in the same cycle wins
        n.icr = (c_icr ? 8'h00 : s.icr) | event_i;
        n.sum_bit = (c_inb ? 1'b0 : s.sum_bit)
            | (|(n.icr & n.chg_en));
        n.sum_prev = sum;
        n.rqs = (c_rqs ? 1'b0 : s.rqs)
            | (|(sum & ~s.sum_prev));
        n.srq = n.rqs;
        n.stb = stb;
        n.ist = ist;
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            s <= '0;
            s.hdr <= `GSP_HDR_RST;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state register
    assign bus.dev_dio = s.dio;
    assign bus.dev_dio_oe = s.oe;
    assign bus.ack = s.ack;
    assign bus.srq = s.srq;
    assign status_byte_o = s.stb;
    assign ist_o = s.ist;
endmodule : gsp_device

// ==== design/gsp_controller.sv ====
// Bus controller end driven from an Avalon-MM slave
`timescale 1ns/1ps
`include "gsp_map.svh"
module gsp_controller import gsp_pkg::*; #(
    parameter logic [3:0] RD_TMO = `GSP_RD_TMO
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    gsp_if.ctl bus,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    // A zero wait would time out before any answer
    if (RD_TMO == 4'h0) begin : g_bad_tmo
        $error("read timeout must be nonzero");
    end

    gsp_ctl_s s;
    gsp_ctl_s n;
    logic req;

    assign req = avs_read_i | avs_write_i;

    // Next state
    always_comb begin
        n = s;
        n.dav = 1'b0;
        n.dio_oe = 1'b0;
        n.rd = 1'b0;
        n.wreq = ~(req & s.wreq);
        // First cycle of an access loads read data
        if (req && s.wreq) begin
            n.rdata = 32'h0;
            case (avs_address_i)
                `GSP_A_RX: n.rdata = {23'h0, s.rx_v, s.rx};
                `GSP_A_PP: n.rdata = {24'h0, s.ppr};
                `GSP_A_ST: n.rdata = {28'h0, s.rx_err,
                    s.st != GSP_C_IDLE, s.rx_v, bus.srq};
                default: ;
            endcase
        end
        // Reading the byte clears valid; a capture in the same cycle wins
        if (req && !s.wreq && avs_read_i
                && avs_address_i == `GSP_A_RX) begin
            n.rx_v = 1'b0;
        end
        // Link sequencing
        unique case (s.st)
            GSP_C_IDLE: ;
            GSP_C_RD: begin
                if (bus.ack) begin
                    n.rx = bus.dio_bus;
                    n.rx_v = 1'b1;
                    n.st = GSP_C_IDLE;
                end else if (s.tmo == RD_TMO) begin
                    n.rx = 8'h00;
                    n.rx_v = 1'b1;
                    n.rx_err = 1'b1;
                    n.st = GSP_C_IDLE;
                end else begin
                    n.tmo = s.tmo + 4'h1;
                end
            end
            GSP_C_PP1: n.st = GSP_C_PP2;
            GSP_C_PP2: begin
                n.ppr = bus.dio_bus;
                n.idy = 1'b0;
                n.st = GSP_C_IDLE;
            end
        endcase
        // Completing edge of an access
        if (req && !s.wreq) begin
            if (avs_write_i && s.st == GSP_C_IDLE) begin
                case (avs_address_i)
                    `GSP_A_TX: begin
                        n.dio = avs_writedata_i[7:0];
                        n.atn = avs_writedata_i[`GSP_TX_ATN];
                        n.dav = 1'b1;
                        n.dio_oe = 1'b1;
                    end
                    `GSP_A_RX: begin
                        n.st = GSP_C_RD;
                        n.rd = 1'b1;
                        n.tmo = 4'h0;
                        n.rx_v = 1'b0;
                        n.rx_err = 1'b0;
                    end
                    `GSP_A_PP: begin
                        n.st = GSP_C_PP1;
                        n.idy = 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            s <= '0;
            s.wreq <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state register
    assign avs_readdata_o = s.rdata;
    assign avs_waitrequest_o = s.wreq;
    assign bus.ctl_dio = s.dio;
    assign bus.ctl_dio_oe = s.dio_oe;
    assign bus.atn = s.atn;
    assign bus.dav = s.dav;
    assign bus.rd = s.rd;
    assign bus.idy = s.idy;
endmodule : gsp_controller

// ==== tb/gsp_checker.sv ====
// Link checker for the status poll responder
`timescale 1ns/1ps
module gsp_checker (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic rd,
    input wire logic idy,
    input wire logic dav,
    input wire logic ack,
    input wire logic srq,
    input wire logic [7:0] dio_bus,
    input wire logic [7:0] dev_dio_oe
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    // Talker byte timing and drive
    ack_after_rd_a: assert property (ack |-> $past(rd))
        else $error("talker byte without read request");
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("talker byte held too long");
    ack_drive_a: assert property (ack |-> dev_dio_oe == 8'hFF)
        else $error("talker byte not driven on all lines");
    // Request bit release after a poll
    poll_clears_srq_a: assert property (ack && dio_bus[6] |=> !srq)
        else $error("request line held after poll");
    srq_fall_a: assert property ($fell(srq) |-> ack || $past(dav))
        else $error("request line dropped without poll or clear");
    // Parallel poll drive
    pp_one_line_a: assert property (idy |=> $onehot0(dev_dio_oe))
        else $error("parallel poll drives more than one line");
    quiet_bus_a: assert property (
        !idy && !$past(idy) && !ack |-> dev_dio_oe == 8'h00)
        else $error("device drives data lines outside a poll");
    pp_true_a: assert property (
        $onehot(dev_dio_oe) |-> (dio_bus & dev_dio_oe) == dev_dio_oe)
        else $error("parallel poll line not driven high");
    // Main scenarios reached
    cover property (ack && dio_bus[6]);
    cover property ($fell(srq));
    cover property (idy && dev_dio_oe != 8'h00);
endmodule : gsp_checker

// ==== tb/testbench.sv ====
// Self-checking bench for controller and responder
`timescale 1ns/1ps
`include "gsp_map.svh"
module testbench import gsp_pkg::*;;
    localparam logic [7:0] PA = 8'h04;
    logic ref_clk_i;
    logic reset_i;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_wdata;
    logic [31:0] avs_rdata;
    logic avs_wait;
    logic [7:0] event_v;
    logic [7:0] status_byte;
    logic ist;
    logic [7:0] v;
    logic [31:0] q;
    int fails;
    int n_checks;
    gsp_if link ();
    gsp_device #(.PRI_ADDR(PA[4:0])) gsp_device_i (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus(link),
        .event_i(event_v), .status_byte_o(status_byte), .ist_o(ist));
    gsp_controller #(.RD_TMO(4'h4)) gsp_controller_i (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus(link),
        .avs_address_i(avs_address), .avs_read_i(avs_read),
        .avs_write_i(avs_write), .avs_writedata_i(avs_wdata),
        .avs_readdata_o(avs_rdata), .avs_waitrequest_o(avs_wait));
    gsp_checker gsp_checker_i (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .rd(link.rd),
        .idy(link.idy), .dav(link.dav), .ack(link.ack), .srq(link.srq),
        .dio_bus(link.dio_bus), .dev_dio_oe(link.dev_dio_oe));

    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // One Avalon access, held until waitrequest is seen low
    task automatic av(input logic [3:0] a, input logic w,
            input logic [31:0] d, output logic [31:0] r);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_wdata <= d;
        do begin
            @(posedge ref_clk_i);
        end while (avs_wait !== 1'b0);
        r = avs_rdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk_i);
    endtask : av

    task automatic wbusy();
        logic [31:0] r;
        do begin
            av(`GSP_A_ST, 1'b0, 32'h0, r);
        end while (r[2] !== 1'b0);
    endtask : wbusy

    task automatic tx(input logic [7:0] b, input logic a);
        logic [31:0] r;
        wbusy();
        av(`GSP_A_TX, 1'b1, {23'h0, a, b}, r);
        wbusy();
    endtask : tx

    // Talker read: start, wait for valid, fetch byte
    task automatic rdb(output logic [7:0] b);
        logic [31:0] r;
        av(`GSP_A_RX, 1'b1, 32'h0, r);
        do begin
            av(`GSP_A_ST, 1'b0, 32'h0, r);
        end while (r[1] !== 1'b1);
        av(`GSP_A_RX, 1'b0, 32'h0, r);
        b = r[7:0];
    endtask : rdb

    task automatic addr(input logic [7:0] a);
        tx(`GSP_UNL, 1'b1);
        tx(`GSP_UNT, 1'b1);
        tx(a + PA, 1'b1);
    endtask : addr

    task automatic setr(input logic [7:0] op, input logic [7:0] d);
        addr(`GSP_LAG);
        tx(op, 1'b0);
        tx(d, 1'b0);
    endtask : setr

    task automatic qry(input logic [7:0] op, output logic [7:0] b);
        addr(`GSP_LAG);
        tx(op, 1'b0);
        addr(`GSP_TAG);
        rdb(b);
    endtask : qry

    task automatic spoll(output logic [7:0] b);
        addr(`GSP_TAG);
        tx(`GSP_SPE, 1'b1);
        rdb(b);
        tx(`GSP_SPD, 1'b1);
    endtask : spoll

    task automatic pulse();
        event_v <= 8'h01;
        @(posedge ref_clk_i);
        event_v <= 8'h00;
        repeat (3) @(posedge ref_clk_i);
    endtask : pulse

    task automatic ppoll(output logic [31:0] r);
        wbusy();
        av(`GSP_A_PP, 1'b1, 32'h0, r);
        wbusy();
        av(`GSP_A_PP, 1'b0, 32'h0, r);
    endtask : ppoll

    // Reset state, unmapped read, header control
    task automatic t_reset();
        chk("status", status_byte, 8'h00);
        av(4'h2, 1'b0, 32'h0, q);
        chk("unmapped", q, 32'h0);
        qry(`GSP_OP_QCHG, v);
        chk("header", v, `GSP_OP_QCHG);
        rdb(v);
        chk("change reg", v, 8'h00);
        setr(`GSP_OP_HDR, 8'h00);
        qry(`GSP_OP_QCHG, v);
        chk("bare", v, 8'h00);
    endtask : t_reset

    // Summary bit, request, serial poll, clear status
    task automatic t_serial();
        setr(`GSP_OP_CHGEN, 8'h01);
        setr(`GSP_OP_SRE, 8'h01);
        pulse();
        chk("status", status_byte, 8'h41);
        chk("srq", link.srq, 1'b1);
        spoll(v);
        chk("poll", v, 8'h41);
        chk("srq", link.srq, 1'b0);
        chk("status", status_byte, 8'h01);
        pulse();
        chk("srq", link.srq, 1'b0);
        qry(`GSP_OP_QCHG, v);
        chk("change reg", v, 8'h01);
        qry(`GSP_OP_QCHG, v);
        chk("change reg", v, 8'h00);
        addr(`GSP_LAG);
        tx(`GSP_OP_CLS, 1'b0);
        chk("status", status_byte, 8'h00);
        pulse();
        chk("srq", link.srq, 1'b1);
        spoll(v);
        chk("poll", v, 8'h41);
    endtask : t_serial

    // Status query clears the summary bit only; message and request bits stay
    task automatic t_stbq();
        setr(`GSP_OP_SRE, 8'h00);
        pulse();
        qry(`GSP_OP_QCHG, v);
        qry(`GSP_OP_QSTB, v);
        chk("stb", v & 8'hEF, 8'h01);
        chk("status", status_byte & 8'hEF, 8'h00);
    endtask : t_stbq

    // Parallel poll on every line, query, unconfigure
    task automatic t_pp();
        setr(`GSP_OP_PRE, 8'h01);
        pulse();
        for (int i = 0; i < 8; i++) begin
            addr(`GSP_LAG);
            tx(`GSP_PPC, 1'b1);
            tx(8'h68 | 8'(i), 1'b1);
            tx(`GSP_UNL, 1'b1);
            ppoll(q);
            chk("pp", q[7:0], 8'h01 << i);
        end
        chk("ist", ist, 1'b1);
        qry(`GSP_OP_QIST, v);
        chk("ist query", v, 8'h01);
        setr(`GSP_OP_PRE, 8'h00);
        chk("ist", ist, 1'b0);
        qry(`GSP_OP_QIST, v);
        chk("ist query", v, 8'h00);
        ppoll(q);
        chk("pp", q[7:0], 8'h00);
        tx(`GSP_PPU, 1'b1);
        setr(`GSP_OP_PRE, 8'h01);
        ppoll(q);
        chk("pp", q[7:0], 8'h00);
    endtask : t_pp

    // Reset in mid-run drops the request and restores headers
    task automatic t_rst();
        setr(`GSP_OP_SRE, 8'h01);
        repeat (3) @(posedge ref_clk_i);
        chk("srq", link.srq, 1'b1);
        reset_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
        chk("srq", link.srq, 1'b0);
        chk("status", status_byte, 8'h00);
        qry(`GSP_OP_QIST, v);
        chk("header", v, `GSP_OP_QIST);
        rdb(v);
        chk("ist query", v, 8'h00);
    endtask : t_rst

    // Read with no talker times out with error
    task automatic t_refuse();
        tx(`GSP_UNT, 1'b1);
        rdb(v);
        chk("rx", v, 8'h00);
        av(`GSP_A_ST, 1'b0, 32'h0, q);
        chk("error", q[3], 1'b1);
    endtask : t_refuse

    // Clock
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // Watchdog
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        fails++;
        results();
    end

    // Main sequence
    initial begin
        fails = 0;
        n_checks = 0;
        reset_i = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_wdata = 32'h0;
        event_v = 8'h00;
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
        t_reset();
        t_serial();
        t_stbq();
        t_pp();
        t_rst();
        t_refuse();
        results();
    end
endmodule : testbench
